//--- logic/fbl_cmd.sv
// serial command interpreter for block locks, resets, unique id, params
// assumes link pins are asynchronous to i_ref_clk (link clock <= 5 MHz)
//
// Overview of operation
// - with protection select set, per-block lock bits decide write protection
// - with select clear, complement bit and five-bit protect field decide it
// - lock bits are volatile and all read 1 after power-up or reset
// - lock opcode plus address sets the addressed block or sector lock
// - unlock opcode plus address clears the addressed block or sector lock
// - lock commands ending off a byte boundary are rejected
// - lock status read returns the addressed lock bit in first byte
// - status read and global commands accept single or quad opcode
// - global lock sets every lock bit
// - global unlock clears every lock bit
// - reset runs only directly after reset enable; others cancel it
// - software reset restores defaults except the program/erase fail flag
// - software reset during program or erase aborts that operation
// - after pin reset: standby, write latch, busy and locks at defaults
// - while reset pin low, output floats and program/erase ends
// - recovery lasts 30 us, or 12 ms after erase or register write
// - unique id: four dummy bytes then a fixed 128-bit identifier
// - param read: three address bytes, one dummy, then table bytes
// - raising select during param data stops the output drive
`timescale 1ns/100ps
`include "fbl_defs.svh"
`default_nettype none
module fbl_cmd #(
   parameter int unsigned    P_READY_LONG_CYC = `FBL_READY_LONG_CYC,
   // arbitrary value, one per part in silicon
   parameter logic [127:0]   P_UNIQUE_ID = 128'h0123456789ABCDEF0011223344556677
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_reset_n,
   input  wire logic         i_sclk,
   input  wire logic         i_cs_n,
   input  wire logic [3:0]   i_sio,
   output logic      [3:0]   o_sio,
   output logic      [3:0]   o_sio_oe,
   input  wire logic         i_rst_pin_n,
   input  wire logic         i_qpi_mode,
   input  wire logic         i_protection_select_bit,
   input  wire logic         i_protect_complement_bit,
   input  wire logic [4:0]   i_block_protect_field,
   input  wire logic         i_busy_flag,
   input  wire logic         i_long_op,
   input  wire logic         i_pe_fail_set,
   input  wire logic [23:0]  i_query_addr,
   output logic              o_query_protected,
   output logic [23:0]       o_param_addr,
   input  wire logic [7:0]   i_param_data,
   output logic              o_write_enable_latch,
   output logic              o_program_erase_fail_flag,
   output logic              o_abort_program,
   output logic              o_recovering,
   output fbl_pkg::fbl_state_t o_state
);
   import fbl_pkg::*;

   localparam int unsigned LOCKS = `FBL_NUM_LOCKS;

   // blocks 0 and 255 lock per 4 KB sector, entries 256..287
   function automatic logic [8:0] lock_idx(input logic [23:0] a);
      if (a[23:16] == 8'h00 || a[23:16] == 8'hFF)
         lock_idx = {4'h8, a[23], a[15:12]};
      else
         lock_idx = {1'b0, a[23:16]};
   endfunction

   logic [6:0]       sync1, sync2;
   fbl_state_t       state, next_state;
   logic [7:0]       sh_in, next_sh_in, opcode, next_opcode;
   logic [7:0]       out_sh, next_out_sh, shifted, load_byte;
   logic [3:0]       bit_cnt, next_bit_cnt, byte_cnt, next_byte_cnt;
   logic [3:0]       out_bits, next_out_bits, out_idx, next_out_idx;
   logic [3:0]       so, next_so, lanes, sum_bits;
   logic [23:0]      addr, next_addr;
   logic [18:0]      rec_cnt, next_rec_cnt;
   logic [LOCKS-1:0] locks, next_locks;
   logic [8:0]       hit, span;
   logic [9:0]       bp_sum;
   logic             sclk_q, cs_q, write_enable_latch, next_wel, armed, next_armed;
   logic             pef, next_pef, abort, next_abort;
   logic             pin_n, cs_n, sclk_rise, sclk_fall;
   logic             lock_all, unlock_all, lock_one, unlock_one;
   logic             soft_rst, frame_end, on_boundary;

   // two flops on every pin before anything looks at it
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         sync1  <= `FBL_SYNC_RST;
         sync2  <= `FBL_SYNC_RST;
         sclk_q <= 1'b0;
         cs_q   <= 1'b1;
      end else begin
         sync1  <= {i_rst_pin_n, i_cs_n, i_sclk, i_sio};
         sync2  <= sync1;
         sclk_q <= sync2[4];
         cs_q   <= sync2[5];
      end
   end

   assign pin_n     = sync2[6];
   assign cs_n      = sync2[5];
   assign sclk_rise = sync2[4] & ~sclk_q;
   assign sclk_fall = ~sync2[4] & sclk_q;
   assign lanes     = i_qpi_mode ? 4'h4 : 4'h1;
   assign sum_bits  = bit_cnt + lanes;
   assign shifted   = i_qpi_mode ? {sh_in[3:0], sync2[3:0]}
                                 : {sh_in[6:0], sync2[0]};
   assign hit       = lock_idx(addr);
   assign frame_end = cs_n & ~cs_q & (state == ST_CMD || state == ST_DATA);
   assign on_boundary = (bit_cnt == 4'h0);

   always_comb begin
      case (opcode)
         `FBL_OP_LOCK_STAT: load_byte = {7'h00, locks[hit]};
         `FBL_OP_UNIQUE_ID: load_byte = P_UNIQUE_ID[8*(15-out_idx) +: 8];
         default:           load_byte = i_param_data;
      endcase
   end

   always_comb begin
      next_state    = state;
      next_sh_in    = sh_in;
      next_bit_cnt  = bit_cnt;
      next_byte_cnt = byte_cnt;
      next_opcode   = opcode;
      next_addr     = addr;
      next_out_sh   = out_sh;
      next_out_bits = out_bits;
      next_out_idx  = out_idx;
      next_so       = so;
      next_wel      = write_enable_latch;
      next_armed    = armed;
      next_pef      = pef | i_pe_fail_set;
      next_abort    = 1'b0;
      next_rec_cnt  = rec_cnt;
      lock_all      = 1'b0;
      unlock_all    = 1'b0;
      lock_one      = 1'b0;
      unlock_one    = 1'b0;
      soft_rst      = 1'b0;
      if (!pin_n) begin
         next_state   = ST_RECOVER;
         next_wel     = 1'b0;
         next_armed   = 1'b0;
         lock_all     = 1'b1;
         next_abort   = i_busy_flag;
         next_rec_cnt = (i_busy_flag && i_long_op)
                        ? 19'(P_READY_LONG_CYC - 1)
                        : 19'(`FBL_READY_SHORT_CYC - 1);
      end else if (state == ST_RECOVER) begin
         if (rec_cnt == 19'h00000)
            next_state = ST_IDLE;
         else
            next_rec_cnt = rec_cnt - 19'h00001;
      end else if (frame_end) begin
         next_state = ST_IDLE;
         if (byte_cnt != 4'h0)
            next_armed = 1'b0;
         if (on_boundary) begin
            case (opcode)
               `FBL_OP_WRITE_EN:
                  if (byte_cnt == `FBL_LEN_OPONLY) next_wel = 1'b1;
               `FBL_OP_WRITE_DIS:
                  if (byte_cnt == `FBL_LEN_OPONLY) next_wel = 1'b0;
               `FBL_OP_RESET_EN:
                  next_armed = (byte_cnt == `FBL_LEN_OPONLY);
               `FBL_OP_RESET:
                  soft_rst = armed && byte_cnt == `FBL_LEN_OPONLY;
               `FBL_OP_BLK_LOCK:
                  lock_one = write_enable_latch && byte_cnt == `FBL_LEN_ADDR;
               `FBL_OP_BLK_UNLOCK:
                  unlock_one = write_enable_latch && byte_cnt == `FBL_LEN_ADDR;
               `FBL_OP_GLB_LOCK:
                  lock_all = write_enable_latch && byte_cnt == `FBL_LEN_OPONLY;
               `FBL_OP_GLB_UNLOCK:
                  unlock_all = write_enable_latch && byte_cnt == `FBL_LEN_OPONLY;
               default: ;
            endcase
         end
         if (lock_one || unlock_one || lock_all || unlock_all)
            next_wel = 1'b0;
         if (soft_rst) begin
            next_state   = ST_RECOVER;
            next_wel     = 1'b0;
            next_armed   = 1'b0;
            lock_all     = 1'b1;
            next_abort   = i_busy_flag;
            next_rec_cnt = (i_busy_flag && i_long_op)
                           ? 19'(P_READY_LONG_CYC - 1)
                           : 19'(`FBL_READY_SHORT_CYC - 1);
         end
      end else if (cs_n) begin
         next_state = ST_IDLE;
      end else if (state == ST_IDLE) begin
         next_state    = ST_CMD;
         next_bit_cnt  = 4'h0;
         next_byte_cnt = 4'h0;
         next_out_idx  = 4'h0;
         next_opcode   = 8'h00;
      end else if (state == ST_CMD && sclk_rise) begin
         next_sh_in   = shifted;
         next_bit_cnt = (sum_bits == 4'h8) ? 4'h0 : sum_bits;
         if (sum_bits == 4'h8) begin
            if (byte_cnt != 4'hF)
               next_byte_cnt = byte_cnt + 4'h1;
            if (byte_cnt == 4'h0)
               next_opcode = shifted;
            else if (byte_cnt < `FBL_LEN_ADDR)
               next_addr = {addr[15:0], shifted};
            if ((opcode == `FBL_OP_LOCK_STAT && byte_cnt == 4'h3) ||
                (opcode == `FBL_OP_PARAM && byte_cnt == 4'h4) ||
                (opcode == `FBL_OP_UNIQUE_ID && byte_cnt == 4'h4)) begin
               next_state    = ST_DATA;
               next_out_bits = 4'h8;
               next_out_sh   = load_byte;
               next_out_idx  = out_idx + 4'h1;
               if (opcode == `FBL_OP_PARAM)
                  next_addr = addr + 24'h000001;
               // last address byte is not in addr yet
               if (opcode == `FBL_OP_LOCK_STAT)
                  next_out_sh = {7'h00, locks[lock_idx(next_addr)]};
            end
         end
      end else if (state == ST_DATA && sclk_fall) begin
         next_so     = i_qpi_mode ? out_sh[7:4] : {2'b00, out_sh[7], 1'b0};
         next_out_sh = i_qpi_mode ? {out_sh[3:0], 4'h0}
                                  : {out_sh[6:0], 1'b0};
         next_out_bits = out_bits - lanes;
         if (out_bits == lanes) begin
            next_out_bits = 4'h8;
            next_out_sh   = load_byte;
            next_out_idx  = out_idx + 4'h1;
            if (opcode == `FBL_OP_PARAM)
               next_addr = addr + 24'h000001;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < LOCKS; gi++) begin : g_lock
         assign next_locks[gi] =
            lock_all   ? 1'b1 :
            unlock_all ? 1'b0 :
            (lock_one && hit == 9'(gi))   ? 1'b1 :
            (unlock_one && hit == 9'(gi)) ? 1'b0 :
            locks[gi];
      end
   endgenerate

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         state    <= ST_IDLE;
         sh_in    <= 8'h00;
         bit_cnt  <= 4'h0;
         byte_cnt <= 4'h0;
         opcode   <= 8'h00;
         addr     <= 24'h000000;
         out_sh   <= 8'h00;
         out_bits <= 4'h0;
         out_idx  <= 4'h0;
         so       <= 4'h0;
         write_enable_latch      <= 1'b0;
         armed    <= 1'b0;
         pef      <= 1'b0;
         abort    <= 1'b0;
         rec_cnt  <= 19'h00000;
         locks    <= '1;
      end else begin
         state    <= next_state;
         sh_in    <= next_sh_in;
         bit_cnt  <= next_bit_cnt;
         byte_cnt <= next_byte_cnt;
         opcode   <= next_opcode;
         addr     <= next_addr;
         out_sh   <= next_out_sh;
         out_bits <= next_out_bits;
         out_idx  <= next_out_idx;
         so       <= next_so;
         write_enable_latch      <= next_wel;
         armed    <= next_armed;
         pef      <= next_pef;
         abort    <= next_abort;
         rec_cnt  <= next_rec_cnt;
         locks    <= next_locks;
      end
   end

   // protect field counts top blocks: 0 none, n gives 2^(n-1), 9+ all
   always_comb begin
      if (i_block_protect_field == 5'h00)
         span = 9'h000;
      else if (i_block_protect_field > 5'h09)
         span = 9'h100;
      else
         span = 9'h001 << (i_block_protect_field - 5'h01);
      bp_sum = {2'b00, i_query_addr[23:16]} + {1'b0, span};
   end

   assign o_query_protected = i_protection_select_bit
      ? locks[lock_idx(i_query_addr)]
      : ((bp_sum >= 10'h100) ^ i_protect_complement_bit);

   // drive only in data phase; pin reset or select high floats at once
   assign o_sio_oe = (state == ST_DATA && pin_n && !cs_n)
                     ? (i_qpi_mode ? 4'hF : 4'h2) : 4'h0;
   assign o_sio                     = so;
   assign o_param_addr              = addr;
   assign o_write_enable_latch      = write_enable_latch;
   assign o_program_erase_fail_flag = pef;
   assign o_abort_program           = abort;
   assign o_recovering              = (state == ST_RECOVER);
   assign o_state                   = state;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   chk_pin_locks: assert property (!pin_n |=> &locks)
      else $error("locks not set after pin reset");
   chk_pin_float: assert property (!pin_n |-> o_sio_oe == 4'h0)
      else $error("output driven during pin reset");
   chk_gate_wel: assert property (frame_end && !write_enable_latch && !soft_rst &&
      pin_n |=> $stable(locks))
      else $error("locks changed without write enable");
   chk_glb_lock: assert property (lock_all |=> locks == '1)
      else $error("global lock missed a bit");
   chk_glb_unlock: assert property (unlock_all |=> locks == '0)
      else $error("global unlock missed a bit");
   chk_one_unlock: assert property (unlock_one |=> !locks[$past(hit)])
      else $error("addressed lock not cleared");
   chk_reset_pair: assert property (soft_rst |-> armed &&
      opcode == `FBL_OP_RESET) else $error("reset without enable");
   chk_keep_fail: assert property (soft_rst && pef |=> pef)
      else $error("fail flag lost on software reset");
   chk_sel_lock: assert property (i_protection_select_bit |->
      o_query_protected == locks[lock_idx(i_query_addr)])
      else $error("protection ignores lock bits");
   chk_end_drive: assert property ($rose(cs_n) |-> ##[0:1]
      o_sio_oe == 4'h0) else $error("drive held after deselect");

   cov_glb_lock:   cover property (lock_all && pin_n);
   cov_unlock_one: cover property (unlock_one);
   cov_soft_rst:   cover property (soft_rst);
   cov_uid_out:    cover property (state == ST_DATA &&
                                   opcode == `FBL_OP_UNIQUE_ID);
endmodule // fbl_cmd
`default_nettype wire

//--- common/fbl_defs.svh
// constants of the flash lock, reset and identification command block
// assumes a 40 MHz core clock and a 3-byte address serial host link
`ifndef FBL_DEFS_SVH
`define FBL_DEFS_SVH
`define FBL_OP_WRITE_EN   8'h06
`define FBL_OP_WRITE_DIS  8'h04
`define FBL_OP_BLK_LOCK   8'h36
`define FBL_OP_BLK_UNLOCK 8'h39
`define FBL_OP_LOCK_STAT  8'h3D
`define FBL_OP_GLB_LOCK   8'h7E
`define FBL_OP_GLB_UNLOCK 8'h98
`define FBL_OP_RESET_EN   8'h66
`define FBL_OP_RESET      8'h99
`define FBL_OP_UNIQUE_ID  8'h4B
`define FBL_OP_PARAM      8'h5A
// bytes in a frame before data out, opcode counted
`define FBL_LEN_OPONLY    4'h1
`define FBL_LEN_ADDR      4'h4
`define FBL_LEN_ADDR_DUMMY 4'h5
`define FBL_LEN_DUMMY4    4'h5
`define FBL_NUM_BLOCKS    256
`define FBL_NUM_LOCKS     288
`define FBL_SYNC_RST      7'h60
`define FBL_CLK_MHZ       40
`define FBL_READY_SHORT_US 30
`define FBL_READY_LONG_MS  12
`define FBL_READY_SHORT_CYC (`FBL_READY_SHORT_US * `FBL_CLK_MHZ)
`define FBL_READY_LONG_CYC  (`FBL_READY_LONG_MS * 1000 * `FBL_CLK_MHZ)
`endif

//--- common/fbl_pkg.sv
// types of the flash lock, reset and identification command block
// assumes nothing beyond the defs header
`default_nettype none
package fbl_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA, ST_RECOVER}
      fbl_state_t;
endpackage
`default_nettype wire

//--- bench/fbl_host.sv
// host side of the serial link: mode 0 frames, single or quad lanes
// assumes the bench resolves the lanes; steps on ref clock edges
`timescale 1ns/100ps
`default_nettype none
module fbl_host (
   input  wire logic       i_clk,
   input  wire logic       i_quad,
   input  wire logic [3:0] i_sio,
   output logic            o_sclk,
   output logic            o_cs_n,
   output logic [3:0]      o_sio
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sio  = 4'h5;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // one link clock: 5 cycles low, 3 high, 200 ns
   task automatic pulse();
      tick(5);
      o_sclk = 1'b1;
   endtask
   // header bytes msb first, clocks for xb stray bits, then nrd bytes read
   task automatic frame(input logic [7:0] tx[$], input int xb,
                        input int nrd, output logic [7:0] rx[$]);
      int w;
      logic [7:0] b;
      logic [7:0] s;
      w = i_quad ? 4 : 1;
      rx = {};
      o_cs_n = 1'b0;
      tick(3);
      for (int k = 0; k < tx.size() * 8 + xb; k += w) begin
         b = (k / 8 < tx.size()) ? tx[k / 8] : 8'hA5;
         s = 8'(b >> (8 - w - k % 8));
         o_sio = i_quad ? s[3:0] : {~o_sio[3:1], s[0]};
         pulse();
         tick(3);
         o_sclk = 1'b0;
      end
      b = 8'h00;
      for (int k = 0; k < nrd * 8; k += w) begin
         // released lanes toggle so a stale level never passes
         o_sio = ~o_sio;
         pulse();
         b = i_quad ? {b[3:0], i_sio} : {b[6:0], i_sio[1]};
         if ((k + w) % 8 == 0) rx.push_back(b);
         tick(3);
         o_sclk = 1'b0;
      end
      tick(4);
      o_cs_n = 1'b1;
      o_sio = ~o_sio;
      tick(8);
   endtask
endmodule // fbl_host
`default_nettype wire

//--- bench/fbl_cmd_tb_top.sv
// self-checking bench of the lock, reset and id command block
// assumes fbl_host as link partner and a behavioural lock model
`timescale 1ns/100ps
`default_nettype none
module fbl_cmd_tb_top;
   import fbl_pkg::*;
   // arbitrary value
   localparam logic [127:0] UID = 128'hC3A5_1F2E_9B70_6D48_0A1B_2C3D_4E5F_6172;
   logic clk = 0, rst_n = 0, pin_n = 1, qpi = 0, sel = 1, cmp = 0;
   logic busy = 0, lng = 0, pef = 0, sclk, cs_n, qp, wel_o, fail_o;
   logic abort_o, rec_o;
   logic [4:0] bp = 5'h00;
   logic [23:0] qa = 24'h000000, pa, a;
   logic [3:0] ho, dso, doe, sio_w;
   fbl_state_t st;
   int num_errors = 0, cmp_count = 0, abort_n = 0;
   bit lk[288];
   bit write_enable_latch = 0, ren = 0;
   logic [7:0] rx[$];
   logic [127:0] v;
   always #12.5 clk = ~clk;
   always @(posedge clk) if (abort_o === 1'b1) abort_n++;
   assign sio_w = (doe & dso) | (~doe & ho);
   fbl_host host (.i_clk(clk), .i_quad(qpi), .i_sio(sio_w),
      .o_sclk(sclk), .o_cs_n(cs_n), .o_sio(ho));
   fbl_cmd #(.P_READY_LONG_CYC(200), .P_UNIQUE_ID(UID)) dut (
      .i_ref_clk(clk), .i_reset_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_sio(sio_w), .o_sio(dso), .o_sio_oe(doe), .i_rst_pin_n(pin_n),
      .i_qpi_mode(qpi), .i_protection_select_bit(sel),
      .i_protect_complement_bit(cmp), .i_block_protect_field(bp),
      .i_busy_flag(busy), .i_long_op(lng), .i_pe_fail_set(pef),
      .i_query_addr(qa), .o_query_protected(qp), .o_param_addr(pa),
      .i_param_data(pa[7:0] ^ 8'h3C), .o_write_enable_latch(wel_o),
      .o_program_erase_fail_flag(fail_o), .o_abort_program(abort_o),
      .o_recovering(rec_o), .o_state(st));
   task automatic test_done;
      if (num_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [127:0] s,
                      input logic [127:0] e);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s exp %0h seen %0h", nm, e, s);
      end
   endtask
   // blocks 0 and 255 split into 4 KB sector locks
   function automatic int key(input logic [23:0] x);
      if (x[23:16] == 8'h00 || x[23:16] == 8'hFF)
         return 256 + int'({x[23], x[15:12]});
      return int'(x[23:16]);
   endfunction
   task automatic qchk(input logic [23:0] x);
      bit p;
      qa = x;
      host.tick(2);
      p = bp == 0 ? 0 : bp > 9 ? 1 : x[23:16] >= 256 - (1 << (bp - 1));
      chk("query", qp, sel ? lk[key(x)] : p ^ cmp);
   endtask
   task automatic wrec(input int lim);
      int n;
      n = 0;
      while (rec_o === 1'b1 && n <= lim + 50) begin
         host.tick(1);
         n++;
      end
      if (n > lim + 50) begin
         num_errors++;
         test_done();
      end
      else chk("recover", n >= lim - 12 && n <= lim + 4, 1);
   endtask
   task automatic run(input logic [7:0] t[$], input int xb);
      bit rs;
      host.frame(t, xb, 0, rx);
      rs = 0;
      if (xb == 0) begin
         if (t[0] == 8'h06) write_enable_latch = 1;
         if ((t[0] == 8'h36 || t[0] == 8'h39) && write_enable_latch) begin
            lk[key({t[1], t[2], t[3]})] = t[0] == 8'h36;
            write_enable_latch = 0;
         end
         if ((t[0] == 8'h7E || t[0] == 8'h98) && write_enable_latch) begin
            lk = '{default: t[0] == 8'h7E};
            write_enable_latch = 0;
         end
         rs = t[0] == 8'h99 && ren;
      end
      ren = xb == 0 && t[0] == 8'h66;
      if (rs) begin
         lk = '{default: 1'b1};
         write_enable_latch = 0;
      end
      chk("wel", wel_o, write_enable_latch);
      if (rs) wrec(busy && lng ? 200 : 1200);
   endtask
   task automatic rdst(input logic [23:0] x);
      host.frame({8'h3D, x[23:16], x[15:8], x[7:0]}, 0, 2, rx);
      chk("lock_rd", rx[0], {7'h00, lk[key(x)]});
      chk("lock_rd2", rx[1], {7'h00, lk[key(x)]});
   endtask
   initial begin
      void'($urandom(2343));
      lk = '{default: 1'b1};
      repeat (6) @(posedge clk);
      #1 rst_n = 1;
      host.tick(2);
      for (int i = 0; i < 3; i++) begin
         a = 24'($urandom);
         if (i > 0) a[23:16] = i == 1 ? 8'h00 : 8'hFF;
         qchk(a);
         run({8'h39, a[23:16], a[15:8], a[7:0]}, 0);
         run({8'h06}, 0);
         run({8'h39, a[23:16], a[15:8], a[7:0]}, 0);
         qchk(a);
         qchk(a ^ 24'h001000);
         rdst(a);
         run({8'h06}, 0);
         run({8'h36, a[23:16], a[15:8], a[7:0]}, 0);
         qchk(a);
         rdst(a);
      end
      run({8'h06}, 0);
      run({8'h98}, 3);
      qpi = 1;
      run({8'h98}, 0);
      qchk(24'($urandom));
      rdst(a);
      run({8'h06}, 0);
      run({8'h7E}, 0);
      qpi = 0;
      qchk(24'($urandom));
      run({8'h66}, 0);
      run({8'h06}, 0);
      run({8'h99}, 0);
      chk("no_reset", rec_o, 0);
      pef = 1;
      host.tick(1);
      pef = 0;
      busy = 1;
      lng = 1'($urandom);
      abort_n = 0;
      run({8'h66}, 0);
      run({8'h99}, 0);
      busy = 0;
      lng = 0;
      chk("abort_sw", abort_n, 1);
      chk("fail_kept", fail_o, 1);
      qchk(24'($urandom));
      sel = 0;
      for (int i = 0; i < 24; i++) begin
         bp = 5'(i / 2);
         cmp = i[0];
         a = {8'(256 - (1 << (bp - 1))), 16'h0000};
         qchk(a);
         qchk(a - 24'h1);
         qchk(24'($urandom));
      end
      sel = 1;
      qpi = 1'($urandom);
      host.frame({8'h4B, 8'($urandom), 8'($urandom), 8'($urandom),
         8'($urandom)}, 0, 16, rx);
      v = '0;
      foreach (rx[k]) v = {v[119:0], rx[k]};
      chk("uid", v, UID);
      a = 24'($urandom);
      host.frame({8'h5A, a[23:16], a[15:8], a[7:0], 8'h00}, 0, 3, rx);
      foreach (rx[k]) chk("param", rx[k], 8'(a + k) ^ 8'h3C);
      chk("oe_off", doe, 4'h0);
      run({8'h06}, 0);
      busy = 1;
      lng = 1;
      abort_n = 0;
      pin_n = 0;
      host.tick(8);
      chk("oe_pin", doe, 4'h0);
      chk("abort_pin", abort_o, 1);
      host.tick(40);
      pin_n = 1;
      // pin release is seen two cycles late; keep the long-op cause
      host.tick(3);
      busy = 0;
      lng = 0;
      lk = '{default: 1'b1};
      write_enable_latch = 0;
      wrec(200);
      host.tick(40);
      chk("wel_pin", wel_o, write_enable_latch);
      chk("state", st, ST_IDLE);
      sel = 1'($urandom);
      qchk(24'($urandom));
      rdst(24'($urandom));
      test_done();
   end
endmodule // fbl_cmd_tb_top
`default_nettype wire
